// >>> core/ccc_pkg.sv
package ccc_pkg;

    // ****************************************************************
    // Chain lengths and port widths
    // ****************************************************************
    localparam int BOOT_LEN = 367;
    localparam int BOOT_USED = 304;
    localparam int RUN_LEN = 36;
    localparam int ERR_LEN = 60;
    localparam int PORT_BITS = 6;
    localparam int VIC_MAX = 6;
    localparam int BOOT_ROM_DIV = 8;

    // ****************************************************************
    // Boot chain field positions (least significant bit of each field)
    // ****************************************************************
    localparam int POS_WIDE_IO = 0;
    localparam int POS_RATIO_FLAG = 1;
    localparam int POS_OFFSET_FILL = 2;
    localparam int POS_VIC_THRESH = 3;
    localparam int POS_CLEAN_EVICT = 11;
    localparam int POS_BUS_SIZE = 12;
    localparam int POS_BUS_FORMAT = 14;
    localparam int POS_SPEED = 15;
    localparam int POS_SHADOW_TAG = 19;
    localparam int POS_SNOOP_ONLY = 20;
    localparam int POS_QUICK_DIS = 21;
    localparam int POS_VRD_PIN = 22;
    localparam int POS_CLEAN_DUP0 = 23;
    localparam int POS_VRD_ACK_HOLD = 24;
    localparam int POS_BARRIER = 25;
    localparam int POS_ACK_LIMIT = 26;
    localparam int POS_VIC_CEIL = 31;
    localparam int POS_CLEAN_DUP1 = 34;
    localparam int POS_WW_GAP = 35;
    localparam int POS_RW_GAP = 36;
    localparam int POS_RR_GAP = 42;
    localparam int POS_BANKED = 43;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [5:0] PORT_RST = 6'h00;
    localparam logic [8:0] CNT_RST = 9'h000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {CCC_WAIT_BIST, CCC_LOADING, CCC_LOADED} ccc_state_t;
    typedef enum logic [2:0] {CCC_X1P5, CCC_X2P0, CCC_X2P5, CCC_X3P0, CCC_XBAD} ccc_speed_t;

    // Privileged register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic shift_sel;
        logic [63:0] data;
    } ccc_req_t;

    // Decoded boot configuration
    typedef struct packed {
        logic wide_io;
        logic cache_ratio_flag;
        logic offset_fill_mode;
        logic clean_evict_enable;
        logic [1:0] bus_size;
        logic bus_format;
        ccc_speed_t sysbus_speed;
        logic shadow_tag_mode;
        logic snoop_tag_only_mode;
        logic fast_move_enable;
        logic victim_read_pin_mode;
        logic barrier_offchip_enable;
        logic banked_cache_enable;
    } ccc_cfg_t;

endpackage

// >>> core/ccc_chains.sv
`timescale 1ns/1ps
// Summary of operation
// - Boot chain holds 367 positions; only the low 304 carry configuration.
// - After self-test, 367 boot ROM bits shift in, most significant first.
// - Run-time chain is 36 bits; each data port write adds six bits.
// - Error chain is 60 bits, read through shift port and data port.
// - Each shift port write with bit 0 set removes six bits from the error chain.
// - Data port write captures bits 5:0; they shift in at retirement.
// - Data port read after a shift returns the six shifted-out bits.
// - Writing one to shift port bit 0 moves six bits to the port.
// - Field least significant bit sits at the earliest chain position.
// - Four-bit bus speed field decodes one-hot to 1.5X through 3.0X.
// - Streamed writes start once threshold victims gather; six held at most.
// - Quick move disable bit turns off fast data movement.
// - Ack hold bit stops ack counting for victim read commands.
// - Ack limit and victim ceiling fields bound system bus activity.
// - Write-write and read-write gaps insert idle core cycles; the read-read gap does so only in banked mode.
// - Clean-evict and victim-read pin mode bits enable those features.
// - Single-bit enables select tag, barrier, wide I/O and banked modes.
module ccc_chains
    import ccc_pkg::*;
#(
    parameter int BOOT_BITS = BOOT_LEN,
    parameter int ROM_DIV = BOOT_ROM_DIV
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Boot ROM serial link
    input wire logic bist_done,
    input wire logic rom_data_pin,
    output logic rom_clk,
    output logic boot_loaded,
    // Privileged register access
    input wire ccc_req_t req,
    input wire logic retire,
    output logic [63:0] rd_data,
    output logic rd_valid,
    // Cache unit events
    input wire logic victim_add,
    input wire logic victim_drain,
    input wire logic ack_event,
    input wire logic ack_is_victim_read,
    input wire logic ack_release,
    input wire logic vic_issue,
    input wire logic vic_done,
    input wire logic bc_read_done,
    input wire logic bc_write_done,
    input wire logic err_capture,
    input wire logic [ERR_LEN-1:0] err_info,
    // Configuration and control outputs
    output ccc_cfg_t cfg,
    output logic [RUN_LEN-1:0] run_cfg,
    output logic stream_start,
    output logic ack_stall,
    output logic vic_issue_ok,
    output logic bc_read_ok,
    output logic bc_write_ok
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (BOOT_BITS < BOOT_USED || BOOT_BITS > 511) begin : g_bad_len
        $error("boot chain length out of range");
    end
    // Two-flop pin lag needs at least three cycles per ROM bit
    if (ROM_DIV < 3 || ROM_DIV > 255) begin : g_bad_div
        $error("boot ROM divider out of range");
    end

    // Index of lowest set bit plus one, zero when none set
    function automatic logic [3:0] first_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i + 1);
            end
        end
        return r;
    endfunction

    // ****************************************************************
    // Boot chain loader
    // ****************************************************************
    ccc_state_t state_r, state_nxt;
    logic [BOOT_BITS-1:0] boot_r;
    logic [8:0] bit_cnt_r;
    logic [7:0] div_r;
    logic sync1_r, sync2_r;
    logic tick;
    logic last_bit;

    // Pin synchroniser
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= rom_data_pin;
            sync2_r <= sync1_r;
        end
    end

    // ROM clock divider, sample at end of each period
    assign tick = (state_r == CCC_LOADING) && (div_r == 8'(ROM_DIV - 1));
    assign last_bit = tick && (bit_cnt_r == 9'(BOOT_BITS - 1));
    assign rom_clk = (state_r == CCC_LOADING) && (div_r < 8'(ROM_DIV / 2));
    assign boot_loaded = (state_r == CCC_LOADED);

    // Loader state selection
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CCC_WAIT_BIST: begin
                if (bist_done) begin
                    state_nxt = CCC_LOADING;
                end
            end
            CCC_LOADING: begin
                if (last_bit) begin
                    state_nxt = CCC_LOADED;
                end
            end
            CCC_LOADED: state_nxt = CCC_LOADED;
            default: state_nxt = CCC_WAIT_BIST;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= CCC_WAIT_BIST;
            div_r <= 8'h00;
            bit_cnt_r <= CNT_RST;
        end else begin
            state_r <= state_nxt;
            div_r <= (state_r != CCC_LOADING || tick) ? 8'h00 : div_r + 8'h01;
            if (tick) begin
                bit_cnt_r <= bit_cnt_r + 9'h001;
            end
        end
    end

    // Chain shifts toward the top; the first bit lands at the far end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            boot_r <= '0;
        end else if (tick) begin
            boot_r <= {boot_r[BOOT_BITS-2:0], sync2_r};
        end
    end

    // ****************************************************************
    // Boot field decode
    // ****************************************************************
    wire logic [3:0] speed_code = boot_r[POS_SPEED +: 4];
    wire logic [7:0] vic_thresh = boot_r[POS_VIC_THRESH +: 8];
    wire logic [4:0] ack_limit = boot_r[POS_ACK_LIMIT +: 5];
    wire logic [2:0] vic_ceiling = boot_r[POS_VIC_CEIL +: 3];
    wire logic ww_gap = boot_r[POS_WW_GAP];
    wire logic [5:0] rw_gap = boot_r[POS_RW_GAP +: 6];
    wire logic rr_gap = boot_r[POS_RR_GAP];
    wire logic ack_hold = boot_r[POS_VRD_ACK_HOLD];
    ccc_speed_t speed_dec;

    always_comb begin
        case (speed_code)
            4'h1: speed_dec = CCC_X1P5;
            4'h2: speed_dec = CCC_X2P0;
            4'h4: speed_dec = CCC_X2P5;
            4'h8: speed_dec = CCC_X3P0;
            default: speed_dec = CCC_XBAD;
        endcase
    end

    // Fields taken low bit first; mode enables
    assign cfg.wide_io = boot_r[POS_WIDE_IO];
    assign cfg.cache_ratio_flag = boot_r[POS_RATIO_FLAG];
    assign cfg.offset_fill_mode = boot_r[POS_OFFSET_FILL];
    // Clean evict and victim read pins
    assign cfg.clean_evict_enable = boot_r[POS_CLEAN_EVICT];
    assign cfg.victim_read_pin_mode = boot_r[POS_VRD_PIN];
    assign cfg.bus_size = boot_r[POS_BUS_SIZE +: 2];
    assign cfg.bus_format = boot_r[POS_BUS_FORMAT];
    assign cfg.sysbus_speed = speed_dec;
    assign cfg.shadow_tag_mode = boot_r[POS_SHADOW_TAG];
    assign cfg.snoop_tag_only_mode = boot_r[POS_SNOOP_ONLY];
    assign cfg.fast_move_enable = ~boot_r[POS_QUICK_DIS];
    assign cfg.barrier_offchip_enable = boot_r[POS_BARRIER];
    assign cfg.banked_cache_enable = boot_r[POS_BANKED];

    // ****************************************************************
    // Victim streaming, ack and victim limits
    // ****************************************************************
    logic [2:0] vic_cnt_r;
    logic [4:0] ack_cnt_r;
    logic [2:0] out_vic_r;
    wire logic vic_inc = victim_add && (vic_cnt_r < 3'(VIC_MAX));
    wire logic vic_dec = victim_drain && (vic_cnt_r != 3'h0);
    // Victim read acks not counted while held
    wire logic ack_inc = ack_event && !(ack_hold && ack_is_victim_read) && !ack_stall;
    wire logic ack_dec = ack_release && (ack_cnt_r != 5'h00);
    wire logic vout_inc = vic_issue && vic_issue_ok;
    wire logic vout_dec = vic_done && (out_vic_r != 3'h0);

    // Threshold in decoded form, at most six victims
    assign stream_start = boot_loaded && (first_set(vic_thresh) != 4'h0)
        && ({1'b0, vic_cnt_r} >= first_set(vic_thresh));
    // Bound acknowledges and outstanding victims; all held off while loading
    assign ack_stall = !boot_loaded || (ack_cnt_r >= ack_limit);
    assign vic_issue_ok = boot_loaded && (out_vic_r < vic_ceiling);

    // Event counters
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            vic_cnt_r <= 3'h0;
            ack_cnt_r <= 5'h00;
            out_vic_r <= 3'h0;
        end else begin
            vic_cnt_r <= vic_cnt_r + 3'(vic_inc) - 3'(vic_dec);
            ack_cnt_r <= ack_cnt_r + 5'(ack_inc) - 5'(ack_dec);
            out_vic_r <= out_vic_r + 3'(vout_inc) - 3'(vout_dec);
        end
    end

    // ****************************************************************
    // Board cache idle gaps
    // ****************************************************************
    logic [5:0] wr_gap_r;
    logic rd_gap_r;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_gap_r <= 6'h00;
            rd_gap_r <= 1'b0;
        end else begin
            if (bc_read_done) begin
                wr_gap_r <= rw_gap;
            end else if (bc_write_done) begin
                wr_gap_r <= {5'h00, ww_gap};
            end else if (wr_gap_r != 6'h00) begin
                wr_gap_r <= wr_gap_r - 6'h01;
            end
            rd_gap_r <= bc_read_done ? (rr_gap && cfg.banked_cache_enable) : 1'b0;
        end
    end

    assign bc_write_ok = (wr_gap_r == 6'h00) && !bc_read_done;
    assign bc_read_ok = !rd_gap_r;

    // ****************************************************************
    // Data port, run-time chain and error chain
    // ****************************************************************
    logic [5:0] pend_r;
    logic pend_vld_r;
    logic [5:0] port_r;
    logic [RUN_LEN-1:0] run_r;
    logic [ERR_LEN-1:0] err_r;
    // Only bit 0 of the shift port and bits 5:0 of the data port count
    wire logic data_wr = req.wr && !req.shift_sel;
    wire logic shift_wr = req.wr && req.shift_sel && req.data[0];

    // Capture then shift on retirement; six bits per write
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pend_r <= PORT_RST;
            pend_vld_r <= 1'b0;
            run_r <= '0;
        end else begin
            if (data_wr) begin
                pend_r <= req.data[PORT_BITS-1:0];
            end
            pend_vld_r <= data_wr || (pend_vld_r && !retire);
            if (retire && pend_vld_r) begin
                run_r <= {run_r[RUN_LEN-PORT_BITS-1:0], pend_r};
            end
        end
    end

    // Error capture; destructive six-bit shift out; load port
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            err_r <= '0;
            port_r <= PORT_RST;
        end else begin
            if (shift_wr) begin
                err_r <= {PORT_BITS'(0), err_r[ERR_LEN-1:PORT_BITS]};
                port_r <= err_r[PORT_BITS-1:0];
            end else if (err_capture) begin
                err_r <= err_info;
            end
        end
    end

    // Read returns shifted-out bits; upper bits zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 64'h0000000000000000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= req.rd && !req.shift_sel;
            if (req.rd && !req.shift_sel) begin
                rd_data <= {58'h0, port_r};
            end
        end
    end

    assign run_cfg = run_r;

endmodule

// >>> verif/ccc_chains_monitor.sv
`timescale 1ns/1ps
// ********************
// Port checker
// ********************
module ccc_chains_monitor
    import ccc_pkg::*;
#(
    parameter int BOOT_BITS = BOOT_LEN,
    parameter int ROM_DIV = BOOT_ROM_DIV
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Watched ports
    input wire ccc_req_t req,
    input wire logic retire,
    input wire logic rom_clk,
    input wire logic boot_loaded,
    input wire logic [63:0] rd_data,
    input wire logic rd_valid,
    input wire logic [RUN_LEN-1:0] run_cfg,
    input wire logic stream_start,
    input wire logic ack_stall,
    input wire logic vic_issue_ok
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic rom_clk_r;
    logic [9:0] rise_cnt;
    // Data port read request
    wire logic dread = req.rd && !req.shift_sel;
    // Counts rising ROM clocks during a load
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rom_clk_r <= 1'b0;
            rise_cnt <= 10'h000;
        end else begin
            rom_clk_r <= rom_clk;
            rise_cnt <= rise_cnt + 10'((rom_clk && !rom_clk_r) ? 1 : 0);
        end
    end
    property p_rd_valid;
        dread |=> rd_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("rd_valid missing");
    property p_no_valid;
        !dread |=> !rd_valid;
    endproperty
    a_no_valid: assert property (p_no_valid) else $error("rd_valid unasked");
    property p_rd_upper;
        rd_data[63:6] == 58'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("rd_data upper set");
    property p_rd_hold;
        !dread |=> $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rd_data moved");
    property p_run_retire;
        !retire |=> $stable(run_cfg);
    endproperty
    a_run_retire: assert property (p_run_retire) else $error("run_cfg early");
    property p_loaded_hold;
        boot_loaded |=> boot_loaded;
    endproperty
    a_loaded_hold: assert property (p_loaded_hold) else $error("boot_loaded fell");
    property p_rom_quiet;
        boot_loaded |-> !rom_clk;
    endproperty
    a_rom_quiet: assert property (p_rom_quiet) else $error("rom_clk after load");
    property p_boot_count;
        $rose(boot_loaded) |-> rise_cnt == 10'(BOOT_BITS);
    endproperty
    a_boot_count: assert property (p_boot_count) else $error("boot bit count");
    property p_pre_boot;
        !boot_loaded |-> ack_stall && !vic_issue_ok && !stream_start;
    endproperty
    a_pre_boot: assert property (p_pre_boot) else $error("limits before load");
endmodule

bind ccc_chains ccc_chains_monitor #(.BOOT_BITS(BOOT_BITS), .ROM_DIV(ROM_DIV)) u_ccc_chains_monitor (
    .clock(clock),
    .sys_rst(sys_rst),
    .req(req),
    .retire(retire),
    .rom_clk(rom_clk),
    .boot_loaded(boot_loaded),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .run_cfg(run_cfg),
    .stream_start(stream_start),
    .ack_stall(ack_stall),
    .vic_issue_ok(vic_issue_ok)
);

// >>> verif/ccc_rom_model.sv
`timescale 1ns/1ps
// ********************
// Serial boot ROM
// ********************
module ccc_rom_model
    import ccc_pkg::*;
#(
    parameter int BITS = BOOT_LEN
) (
    // Reset and ROM clock
    input wire logic sys_rst,
    input wire logic rom_clk,
    // Image and serial data
    input wire logic [BITS-1:0] image,
    output logic rom_data_pin
);
    int idx;
    // top bit first
    // Next bit on each rising ROM clock; toggles once the image is spent
    // Reload at reset release, while the ROM clock is low; avoids a start-up race
    always @(posedge rom_clk or negedge sys_rst) begin
        if (!rom_clk) begin
            idx = BITS - 1;
            rom_data_pin = ~image[BITS-1];
        end else if (idx >= 0) begin
            rom_data_pin = image[idx];
            idx = idx - 1;
        end else begin
            rom_data_pin = ~rom_data_pin;
        end
    end
endmodule

// >>> verif/test_ccc_chains.sv
`timescale 1ns/1ps
module test_ccc_chains
    import ccc_pkg::*;
;
    logic clock, sys_rst, bist_done, rom_data_pin, rom_clk, boot_loaded, rd_valid;
    logic stream_start, ack_stall, vic_issue_ok, bc_read_ok, bc_write_ok;
    logic [10:0] ev;
    logic [ERR_LEN-1:0] err_info;
    logic [BOOT_LEN-1:0] image;
    logic [63:0] rd_data;
    logic [RUN_LEN-1:0] run_cfg, erun;
    ccc_req_t req;
    ccc_cfg_t cfg, ecfg;
    int n_fail, total_checks;

    ccc_chains #(.BOOT_BITS(BOOT_LEN), .ROM_DIV(8)) u_ccc_chains (
        .clock(clock), .sys_rst(sys_rst), .bist_done(bist_done),
        .rom_data_pin(rom_data_pin), .rom_clk(rom_clk), .boot_loaded(boot_loaded),
        .req(req), .retire(ev[9]), .rd_data(rd_data), .rd_valid(rd_valid),
        .victim_add(ev[0]), .victim_drain(ev[1]), .ack_event(ev[2]),
        .ack_is_victim_read(ev[3]), .ack_release(ev[4]), .vic_issue(ev[5]),
        .vic_done(ev[6]), .bc_read_done(ev[7]), .bc_write_done(ev[8]),
        .err_capture(ev[10]), .err_info(err_info), .cfg(cfg), .run_cfg(run_cfg),
        .stream_start(stream_start), .ack_stall(ack_stall), .vic_issue_ok(vic_issue_ok),
        .bc_read_ok(bc_read_ok), .bc_write_ok(bc_write_ok)
    );
    ccc_rom_model #(.BITS(BOOT_LEN)) u_ccc_rom_model (
        .sys_rst(sys_rst), .rom_clk(rom_clk), .image(image), .rom_data_pin(rom_data_pin)
    );

    // Core clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ********************
    // Access and compare tasks
    // ********************
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic pulse(input logic [10:0] m);
        @(negedge clock);
        ev = m;
        @(negedge clock);
        ev = 11'h000;
    endtask
    task automatic send(input logic s, input logic [63:0] d);
        @(negedge clock);
        req = '{wr: 1'b1, rd: 1'b0, shift_sel: s, data: d};
    endtask
    // Shift port write, then data port read in the next cycle
    task automatic shift_read(input logic [63:0] d, input logic [5:0] e);
        send(1'b1, d);
        @(negedge clock);
        req = '{wr: 1'b0, rd: 1'b1, shift_sel: 1'b0, data: 64'h0};
        @(negedge clock);
        req = '0;
        chk("rd_valid", 64'h1, 64'(rd_valid));
        chk("rd_data", {58'h0, e}, rd_data);
    endtask
    // Data port write, retired one cycle later
    task automatic run_write(input logic [63:0] d);
        send(1'b0, d);
        @(negedge clock);
        req = '0;
        ev = 11'h200;
        @(negedge clock);
        ev = 11'h000;
        erun = {erun[29:0], d[5:0]};
        @(negedge clock);
        chk("run_cfg", 64'(erun), 64'(run_cfg));
    endtask
    // Build image i, reset, load it and compare decoded fields
    task automatic boot(input int i);
        image = '1;
        image[43:0] = '0;
        image[POS_WIDE_IO] = i[0];
        image[POS_RATIO_FLAG] = (i == 0);
        image[POS_OFFSET_FILL] = (i == 0);
        image[POS_VIC_THRESH +: 8] = 8'h04;
        image[POS_CLEAN_EVICT] = i[1];
        image[POS_CLEAN_DUP0] = i[1];
        image[POS_CLEAN_DUP1] = i[1];
        image[POS_BUS_SIZE +: 2] = 2'(i);
        image[POS_BUS_FORMAT] = i[1];
        image[POS_SPEED +: 4] = 4'(1 << i);
        image[POS_SHADOW_TAG] = i[0];
        image[POS_SNOOP_ONLY] = !i[0];
        image[POS_QUICK_DIS] = i[1];
        image[POS_VRD_PIN] = !i[1];
        image[POS_VRD_ACK_HOLD] = 1'b1;
        image[POS_BARRIER] = i[0];
        image[POS_ACK_LIMIT +: 5] = 5'h03;
        image[POS_VIC_CEIL +: 3] = 3'h2;
        image[POS_RW_GAP +: 6] = 6'h04;
        image[POS_RR_GAP] = i[1];
        image[POS_BANKED] = i[1];
        ecfg = ccc_cfg_t'({i[0], i == 0, i == 0, i[1], 2'(i), i[1], 3'(i), i[0], !i[0],
                           !i[1], !i[1], i[0], i[1]});
        sys_rst = 1'b1;
        bist_done = 1'b0;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        erun = '0;
        chk("reset flags", 64'h2, 64'({boot_loaded, rd_valid, ack_stall, vic_issue_ok}));
        chk("reset rd_data", 64'h0, rd_data);
        chk("reset run_cfg", 64'h0, 64'(run_cfg));
        bist_done = 1'b1;
        for (int k = 0; k < 4000 && boot_loaded !== 1'b1; k++) @(negedge clock);
        chk("boot_loaded", 64'h1, 64'(boot_loaded));
        if (boot_loaded !== 1'b1) report_and_stop();
        chk("cfg", 64'(ecfg), 64'(cfg));
    endtask

    // ********************
    // Main sequence
    // ********************
    initial begin
        sys_rst = 1'b1;
        bist_done = 1'b0;
        req = '0;
        ev = 11'h000;
        err_info = '0;
        image = '0;
        n_fail = 0;
        total_checks = 0;
        for (int i = 0; i < 5; i++) boot((i + 4) % 5);
        repeat (2) pulse(11'h001);
        chk("stream_start", 64'h0, 64'(stream_start));
        pulse(11'h001);
        chk("stream_start", 64'h1, 64'(stream_start));
        pulse(11'h002);
        chk("stream_start", 64'h0, 64'(stream_start));
        repeat (3) pulse(11'h00c);
        chk("ack_stall", 64'h0, 64'(ack_stall));
        repeat (3) pulse(11'h004);
        chk("ack_stall", 64'h1, 64'(ack_stall));
        pulse(11'h010);
        chk("ack_stall", 64'h0, 64'(ack_stall));
        repeat (2) pulse(11'h020);
        chk("vic_issue_ok", 64'h0, 64'(vic_issue_ok));
        pulse(11'h040);
        chk("vic_issue_ok", 64'h1, 64'(vic_issue_ok));
        pulse(11'h080);
        chk("bc_write_ok", 64'h0, 64'(bc_write_ok));
        chk("bc_read_ok", 64'h0, 64'(bc_read_ok));
        for (int k = 0; k < 80 && bc_write_ok !== 1'b1; k++) @(negedge clock);
        chk("bc_write_ok", 64'h1, 64'(bc_write_ok));
        chk("bc_read_ok", 64'h1, 64'(bc_read_ok));
        for (int k = 0; k < 6; k++) run_write(64'hffff_ffff_ffff_ffc0 | 64'(6'(k * 11 + 5)));
        err_info = 60'h1234_5678_9abc_def;
        pulse(11'h400);
        shift_read(64'h1, err_info[5:0]);
        shift_read(64'hffff_ffff_ffff_fffe, err_info[5:0]);
        for (int k = 1; k < 10; k++) shift_read(64'h1, err_info[6*k +: 6]);
        shift_read(64'h1, 6'h00);
        report_and_stop();
    end
endmodule
